// File: rtl/mode_wait_ctrl.sv
/*
 Processor mode register and software wait-state generator.
 Assumes a CPU-side plain register port and synchronous bus/pin inputs.
*/
// Summary of operation
// R1: Mode bits 15..7 select the 128-word vector page.
// R2: Hardware reset sets the vector page to all ones.
// R3: Software reset keeps vector page and ROM-disable bit.
// R4: ROM-disable bit zero makes on-chip ROM visible in program space.
// R5: ROM-disable bit loads from mode pin at reset; software may change it.
// R6: Overlay bit maps RAM into program space except page 0.
// R7: Visibility off holds the last external address on the pins.
// R8: Visibility on drives internal program addresses onto the pins.
// R9: Data-ROM bit maps upper on-chip memory into data space.
// R10: Clock-output-off bit holds the clock pin high; resets to zero.
// R11: Multiply saturation needs overflow and fractional mode too.
// R12: Store saturation bit enables saturation after the output shift.
// R13: Programmed waits extend a cycle by at most fourteen cycles.
// R14: All-zero wait counts gate off the wait generator clock. Code tests only bits 13..0, so bit 14 of the I/O count is ignored.
// R15: Five 3-bit counts sit in the low 15 bits of wait config.
// R16: Multiplier bit in separate control register scales by 1 or 2.
// R17: Reset gives seven waits everywhere and extended bit zero.
// R18: Extended bit with program fields selects program ranges.
// R19: Upper data count from 8000h up, lower count below.
// R20: Multiplier one doubles counts up to fourteen.
// R21: Count waits, then end cycle once ready is active.
`timescale 1ns/1ps
module mode_wait_ctrl
   import mode_wait_pkg::*;
(
   input  wire logic        ref_clk,        // Processor clock
   input  wire logic        srst,           // Hardware reset
   input  wire logic        clk_en,         // Clock enable
   input  wire logic        soft_reset,     // Software reset pulse
   input  wire logic        rom_mode_pin,   // Mode pin level
   input  wire logic [7:0]  reg_addr,       // Register address
   input  wire logic [15:0] reg_wdata,      // Register write data
   input  wire logic        reg_wr,         // Write strobe
   input  wire logic        reg_rd,         // Read strobe
   input  wire logic        overflow_mode_bit,   // CPU overflow mode
   input  wire logic        fractional_mode_bit, // CPU fractional mode
   input  wire logic [22:0] prog_addr,      // Internal program address
   input  wire logic        clk_src,        // Clock for output pin
   input  wire logic        ext_req,        // External access start
   input  wire logic [1:0]  ext_space,      // Program, data or I/O
   input  wire logic [22:0] ext_addr,       // External access address
   input  wire logic        ready_in,       // External ready
   output logic [15:0]      reg_rdata,      // Read data
   output logic [8:0]       vector_page_field,   // Vector page
   output logic [15:0]      vector_base,    // Vector page base address
   output logic             rom_in_prog,    // ROM in program space
   output logic             ram_in_prog,    // RAM overlay active
   output logic             data_rom_map,   // Memory mapped into data
   output logic             sat_product,    // Saturate before accumulate
   output logic             sat_store,      // Saturate on store
   output logic             clock_output_pin, // Clock output
   output logic [22:0]      ext_addr_pins,  // External address pins
   output logic             ext_busy,       // Access in progress
   output logic             ext_done        // Access end pulse
);
   // ==========================================================
   // Registers
   logic [15:0] mode_r;
   logic [15:0] wait_r;
   logic        mult_r;
   logic        pin_cap_r;
   logic [15:0] rdata_r;
   logic [15:0] vbase_r;
   logic        rom_r, ram_r, data_rom_bit_r, multiply_saturation_bit_r, sst_r, clk_r;
   logic [22:0] apins_r;
   logic        done_r, busy_r;
   logic [3:0]  count_r;
   logic        start_r;

   // ==========================================================
   // Address decode
   wire hit_mode = (reg_addr == OFS_MODE);
   wire hit_wait = (reg_addr == OFS_WAIT);
   wire hit_wctl = (reg_addr == OFS_WCTL);
   wire hit_stat = (reg_addr == OFS_STATUS);
   wire wr_mode  = reg_wr && hit_mode;
   wire wr_wait  = reg_wr && hit_wait;
   wire wr_wctl  = reg_wr && hit_wctl;

   // ==========================================================
   // Per-range base counts
   logic [2:0] base_cnt [NUM_RANGES];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RANGES; gi++) begin : g_fld
         assign base_cnt[gi] = wait_r[3*gi +: 3]; // see R15
      end
   endgenerate

   // ==========================================================
   // Range selection
   wire extended_program_range_bit      = wait_r[BIT_XPA];
   wire prog_hi  = extended_program_range_bit ? ext_addr[22] : ext_addr[15]; // see R18
   wire data_hi  = ext_addr[15];                       // see R19
   wire [2:0] sel_base =
      (ext_space == SPACE_IO)   ? base_cnt[FLD_IO/3]  :
      (ext_space == SPACE_DATA) ? (data_hi ? base_cnt[FLD_DHI/3]
                                           : base_cnt[FLD_DLO/3]) :
      (prog_hi ? base_cnt[FLD_PHI/3] : base_cnt[FLD_PLO/3]);
   // Doubling tops out at fourteen
   wire [3:0] sel_cnt = mult_r ? {sel_base, 1'b0} : {1'b0, sel_base};
   // see R16 R20
   wire all_zero = (wait_r[13:0] == 14'h0);            // see R14
   wire gate_on  = !all_zero;

   // ==========================================================
   // Derived mode outputs
   wire [15:0] vbase_nxt = {mode_r[VEC_HI:VEC_LO], 7'h00}; // see R1
   wire        sat_nxt   = mode_r[BIT_MULTIPLY_SATURATION_BIT] && overflow_mode_bit
                           && fractional_mode_bit;          // see R11
   wire        clk_nxt   = mode_r[BIT_CLOCK_OUTPUT_OFF_BIT] ? 1'b1 : clk_src; // see R10
   wire [22:0] apins_nxt = mode_r[BIT_ADDRESS_VISIBILITY_BIT] ? prog_addr :      // see R8
                           (ext_req ? ext_addr : apins_r);     // see R7
   wire [15:0] status    = {11'h000, gate_on, busy_r, pin_cap_r,
                            mult_r, done_r};
   wire [15:0] rdata_nxt =
      hit_mode ? mode_r :
      hit_wait ? wait_r :
      hit_wctl ? {15'h0000, mult_r} :
      hit_stat ? status : 16'h0000;

   // ==========================================================
   // Register file
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_r  <= {VEC_RESET, 7'h00};   // see R2 R10
         wait_r  <= WAIT_RESET;           // see R17
         mult_r  <= 1'b0;
      end else if (clk_en) begin
         if (wr_mode) begin
            mode_r <= reg_wdata;          // see R5
         end else if (soft_reset) begin
            // Vector page and ROM-disable bit survive
            mode_r[5:0] <= 6'h00;         // see R3
         end
         if (wr_wait) begin
            wait_r <= reg_wdata;
         end
         if (wr_wctl) begin
            mult_r <= reg_wdata[BIT_MULT];
         end
         if (pin_cap_r && !wr_mode) begin
            mode_r[BIT_ROMDIS] <= rom_mode_pin; // see R5
         end
      end
   end

   // ==========================================================
   // Mode pin capture on the first enabled cycle after reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_cap_r <= 1'b1;
      end else if (clk_en) begin
         pin_cap_r <= 1'b0;               // see R5
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_r <= 16'h0000;
         vbase_r <= {VEC_RESET, 7'h00};   // see R2
         rom_r   <= 1'b0;
         ram_r   <= 1'b0;
         data_rom_bit_r  <= 1'b0;
         multiply_saturation_bit_r  <= 1'b0;
         sst_r   <= 1'b0;
         clk_r   <= 1'b0;
         apins_r <= 23'h000000;
      end else if (clk_en) begin
         rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
         vbase_r <= vbase_nxt;
         rom_r   <= !mode_r[BIT_ROMDIS];   // see R4
         ram_r   <= mode_r[BIT_RAM_OVERLAY_BIT];      // see R6
         data_rom_bit_r  <= mode_r[BIT_DATA_ROM_BIT];      // see R9
         multiply_saturation_bit_r  <= sat_nxt;
         sst_r   <= mode_r[BIT_SST];       // see R12
         clk_r   <= clk_nxt;
         apins_r <= apins_nxt;
      end
   end

   // ==========================================================
   // Access launch
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         start_r <= 1'b0;
         count_r <= 4'h0;
      end else if (clk_en) begin
         start_r <= ext_req && !busy_r && !start_r;
         count_r <= sel_cnt;
      end
   end

   logic busy_w, done_w;
   wait_counter u_wait (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .gate_on  (gate_on),
      .start    (start_r),
      .count    (count_r),
      .ready_in (ready_in),
      .busy     (busy_w),
      .done     (done_w)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (clk_en) begin
         busy_r <= busy_w || start_r;
         done_r <= done_w;
      end
   end

   // ==========================================================
   // Port drive
   assign reg_rdata         = rdata_r;
   assign vector_page_field = mode_r[VEC_HI:VEC_LO];
   assign vector_base       = vbase_r;
   assign rom_in_prog       = rom_r;
   assign ram_in_prog       = ram_r;
   assign data_rom_map      = data_rom_bit_r;
   assign sat_product       = multiply_saturation_bit_r;
   assign sat_store         = sst_r;
   assign clock_output_pin  = clk_r;
   assign ext_addr_pins     = apins_r;
   assign ext_busy          = busy_r;
   assign ext_done          = done_r;
endmodule

// File: rtl/mode_wait_pkg.sv
/*
 Constants for the mode map and wait-state controller: register offsets,
 field positions, reset values and counts.
 Assumes nothing of its surroundings.
*/
package mode_wait_pkg;
   // ==========================================================
   // Register offsets (word addresses on the plain port)
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_WAIT   = 8'h01;
   localparam logic [7:0] OFS_WCTL   = 8'h02;
   localparam logic [7:0] OFS_STATUS = 8'h03;
   // ==========================================================
   // Mode register fields
   localparam int VEC_HI      = 15;
   localparam int VEC_LO      = 7;
   localparam int BIT_ROMDIS  = 6;
   localparam int BIT_RAM_OVERLAY_BIT    = 5;
   localparam int BIT_ADDRESS_VISIBILITY_BIT    = 4;
   localparam int BIT_DATA_ROM_BIT    = 3;
   localparam int BIT_CLOCK_OUTPUT_OFF_BIT  = 2;
   localparam int BIT_MULTIPLY_SATURATION_BIT    = 1;
   localparam int BIT_SST     = 0;
   localparam logic [8:0] VEC_RESET = 9'h1FF;
   // ==========================================================
   // Wait-state register fields
   localparam int BIT_XPA     = 15;
   localparam int FLD_IO      = 12;
   localparam int FLD_DHI     = 9;
   localparam int FLD_DLO     = 6;
   localparam int FLD_PHI     = 3;
   localparam int FLD_PLO     = 0;
   localparam int NUM_RANGES  = 5;
   localparam logic [15:0] WAIT_RESET = 16'h7FFF;
   localparam int BIT_MULT    = 0;
   // ==========================================================
   // Access spaces and address boundaries
   localparam logic [1:0] SPACE_PROG = 2'h0;
   localparam logic [1:0] SPACE_DATA = 2'h1;
   localparam logic [1:0] SPACE_IO   = 2'h2;
   localparam logic [6:0] RAM_PAGE0_TOP = 7'h7F;
   localparam int PAGE_SHIFT  = 7;
   localparam int WAIT_MAX    = 14;
endpackage

// File: rtl/wait_counter.sv
/*
 Wait-state counter for one external access.
 Assumes start is a one-cycle pulse while idle and ready_in is synchronous.
*/
`timescale 1ns/1ps
module wait_counter
   import mode_wait_pkg::*;
(
   input  wire logic       ref_clk,   // Clock
   input  wire logic       srst,      // Sync reset
   input  wire logic       clk_en,    // Clock enable
   input  wire logic       gate_on,   // Counter clock enable
   input  wire logic       start,     // Access begins
   input  wire logic [3:0] count,     // Wait states to insert
   input  wire logic       ready_in,  // External ready
   output logic            busy,      // Access in progress
   output logic            done       // Access end pulse
);
   logic [3:0] left_r;
   logic       run_r;
   logic       done_r;
   wire        at_zero = (left_r == 4'h0);
   wire        finish  = run_r && at_zero && ready_in;

   assign busy = run_r;
   assign done = done_r;

   // ==========================================================
   // Count down, then hold until ready
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         left_r <= 4'h0;
         run_r  <= 1'b0;
         done_r <= 1'b0;
      end else if (clk_en) begin
         done_r <= finish;                // see R21
         if (start && !run_r) begin
            left_r <= gate_on ? count : 4'h0; // see R14
            run_r  <= 1'b1;
         end else if (finish) begin
            run_r <= 1'b0;
         end else if (run_r && !at_zero) begin
            left_r <= left_r - 4'h1;      // see R13
         end
      end
   end
endmodule

// File: tb/ext_dev_model.sv
/*
 External device on the parallel bus, answering on the ready line.
 Assumes one-cycle ext_req and ext_done pulses.
*/
`timescale 1ns/1ps
module ext_dev_model (
   input  wire logic       ref_clk,  // Clock
   input  wire logic       ext_req,  // Access start
   input  wire logic       ext_done, // Access end
   input  wire logic [3:0] stall,    // Not-ready cycles
   output logic            ready_in  // Ready to controller
);
   logic [3:0] cnt_r = 4'h0; // Cycles since request
   logic       act_r = 1'b0; // Access open
   logic       tog_r = 1'b0; // Idle pattern
   // Track the open access; idle line changes every cycle
   always_ff @(posedge ref_clk) begin
      tog_r <= !tog_r;
      if (ext_req) begin
         act_r <= 1'b1;
         cnt_r <= 4'h0;
      end else if (ext_done) begin
         act_r <= 1'b0;
      end else if (cnt_r != 4'hF) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   // Slow device holds ready low to stretch the cycle
   assign ready_in = act_r ? (cnt_r >= stall) : tog_r;
endmodule

// File: tb/mode_wait_ctrl_chk.sv
/*
 Port checker for mode_wait_ctrl, bound to every instance.
 Assumes clk_en held high by the bench.
*/
`timescale 1ns/1ps
module mode_wait_ctrl_chk
   import mode_wait_pkg::*;
(
   input wire logic        ref_clk,             // Clock
   input wire logic        srst,                // Reset
   input wire logic        soft_reset,          // Soft reset
   input wire logic [7:0]  reg_addr,            // Address
   input wire logic [15:0] reg_wdata,           // Write data
   input wire logic        reg_wr,              // Write
   input wire logic        reg_rd,              // Read
   input wire logic        overflow_mode_bit,   // Overflow mode
   input wire logic        fractional_mode_bit, // Fraction mode
   input wire logic [22:0] prog_addr,           // Program address
   input wire logic        clk_src,             // Clock source
   input wire logic        ext_req,             // Access request
   input wire logic [15:0] reg_rdata,           // Read data
   input wire logic [8:0]  vector_page_field,   // Vector page
   input wire logic [15:0] vector_base,         // Vector base
   input wire logic        rom_in_prog,         // ROM visible
   input wire logic        ram_in_prog,         // RAM overlay
   input wire logic        data_rom_map,        // Data map
   input wire logic        sat_product,         // Product sat
   input wire logic        sat_store,           // Store sat
   input wire logic        clock_output_pin,    // Clock pin
   input wire logic [22:0] ext_addr_pins,       // Address pins
   input wire logic        ext_done             // Access end
);
   logic vis_r; // Shadow of visibility bit
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // Shadow of the visibility bit
   always_ff @(posedge ref_clk) begin
      if (srst || soft_reset) begin
         vis_r <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_MODE) begin
         vis_r <= reg_wdata[4];
      end
   end
   // Mode read with no soft reset beside it
   sequence mode_rd;
      reg_rd && reg_addr == OFS_MODE && !soft_reset;
   endsequence
   // ==========================================================
   // Assertions
   AST_ROM_MAP: assert property (mode_rd |=>
      rom_in_prog != reg_rdata[6]) else $error("ROM map mismatch");
   AST_OVERLAY: assert property (mode_rd |=>
      ram_in_prog == reg_rdata[5]) else $error("Overlay mismatch");
   AST_DATA_ROM_BIT: assert property (mode_rd |=>
      data_rom_map == reg_rdata[3]) else $error("Data map mismatch");
   AST_SST: assert property (mode_rd |=>
      sat_store == reg_rdata[0]) else $error("Store sat mismatch");
   AST_MULTIPLY_SATURATION_BIT: assert property (mode_rd |=> sat_product ==
      (reg_rdata[1] & $past(overflow_mode_bit) &
      $past(fractional_mode_bit))) else $error("Product sat mismatch");
   AST_CLOCK_OUTPUT_OFF_BIT: assert property (mode_rd |=>
      clock_output_pin == (reg_rdata[2] | $past(clk_src)))
      else $error("Clock pin mismatch");
   AST_RESET_VEC: assert property ($fell(srst) |->
      vector_page_field == 9'h1FF && vector_base == 16'hFF80)
      else $error("Reset page wrong");
   AST_VEC_BASE: assert property (
      vector_base == {$past(vector_page_field), 7'h00})
      else $error("Vector base mismatch");
   AST_ADDR_TRACE: assert property (vis_r ##1 vis_r |->
      ext_addr_pins == $past(prog_addr)) else $error("Trace mismatch");
   AST_ADDR_HOLD: assert property (!vis_r && !ext_req ##1
      !vis_r |-> $stable(ext_addr_pins)) else $error("Address moved");
   // Main scenarios
   COV_CLOCK_OUTPUT_OFF_BIT: cover property (mode_rd ##1 reg_rdata[2]);
   COV_TRACE: cover property (vis_r ##1 vis_r);
   COV_DONE: cover property (ext_done);
endmodule

bind mode_wait_ctrl mode_wait_ctrl_chk i_mode_wait_ctrl_chk (.*);

// File: tb/mode_wait_ctrl_test.sv
/*
 Self-checking bench for mode_wait_ctrl.
 Assumes the external device model and the bound checker.
*/
`timescale 1ns/1ps
module mode_wait_ctrl_test
   import mode_wait_pkg::*;
;
   logic        ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1;
   logic        soft_reset = 1'b0, rom_mode_pin = 1'b1, clk_src = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, ext_req = 1'b0;
   logic        overflow_mode_bit = 1'b0, fractional_mode_bit = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, vector_base, v;
   logic [22:0] prog_addr = 23'h000000, ext_addr = 23'h000000;
   logic [22:0] ext_addr_pins;
   logic [1:0]  ext_space = 2'h0;
   logic [8:0]  vector_page_field;
   logic        ready_in, rom_in_prog, ram_in_prog, data_rom_map;
   logic        sat_product, sat_store, clock_output_pin;
   logic        ext_busy, ext_done;
   logic [3:0]  stall = 4'h0;
   int          fail_count = 0, comparisons = 0, cyc = 0, base, n7;
   mode_wait_ctrl i_mode_wait_ctrl (.*);
   ext_dev_model i_ext_dev_model (.*);
   // Clock, moving clock source and hang limit
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      clk_src <= ~clk_src;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   // ==========================================================
   // Tasks
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset(input logic pin);
      rom_mode_pin <= pin;
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic acc(input logic [1:0] sp, input logic [22:0] a,
                      output int n);
      logic saw;
      saw = 1'b0;
      @(posedge ref_clk);
      ext_req <= 1'b1;
      ext_space <= sp;
      ext_addr <= a;
      @(posedge ref_clk);
      ext_req <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
         if (ext_busy === 1'b1) begin
            saw = 1'b1;
         end
      end while (ext_done !== 1'b1 && n < 100);
      chk("busy", {15'h0, saw}, 16'h0001);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("idle", {15'h0, ext_busy}, 16'h0000);
   endtask
   task automatic waits(input logic [1:0] sp, input logic [22:0] a,
                        input int exp);
      int n;
      acc(sp, a, n);
      chk("waits", 16'(n - base), 16'(exp));
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      do_reset(1'b1);
      rom_mode_pin <= 1'b0;
      rd(OFS_MODE, v);
      chk("mode", v, 16'hFFC0);
      chk("base", vector_base, 16'hFF80);
      chk("rom", {15'h0, rom_in_prog}, 16'h0000);
      rd(OFS_WAIT, v);
      chk("wait", v, 16'h7FFF);
      rd(OFS_WCTL, v);
      chk("wctl", v, 16'h0000);
      rd(OFS_STATUS, v);
      chk("gate", {15'h0, v[4]}, 16'h0001);
      acc(SPACE_IO, 23'h000000, n7);
      wr(OFS_WAIT, 16'h0000);
      rd(OFS_STATUS, v);
      chk("gate", {15'h0, v[4]}, 16'h0000);
      acc(SPACE_IO, 23'h000000, base);
      chk("reset waits", 16'(n7 - base), 16'h0007);
      wr(OFS_WAIT, 16'h14E5);
      waits(SPACE_IO, 23'h000000, 1);
      waits(SPACE_DATA, 23'h008000, 2);
      waits(SPACE_DATA, 23'h007FFF, 3);
      waits(SPACE_PROG, 23'h018000, 4);
      waits(SPACE_PROG, 23'h017FFF, 5);
      wr(OFS_WAIT, 16'h94E5);
      waits(SPACE_PROG, 23'h400000, 4);
      waits(SPACE_PROG, 23'h008000, 5);
      wr(OFS_WCTL, 16'hFFFF);
      rd(OFS_WCTL, v);
      chk("wctl", v, 16'h0001);
      waits(SPACE_DATA, 23'h000000, 6);
      wr(OFS_WAIT, 16'h7FFF);
      waits(SPACE_IO, 23'h000000, 14);
      stall <= 4'h3;
      waits(SPACE_IO, 23'h000000, 14);
      wr(OFS_WAIT, 16'h0000);
      stall <= 4'h9;
      acc(SPACE_IO, 23'h000000, n7);
      chk("stall", {15'h0, n7 > base}, 16'h0001);
      stall <= 4'h0;
      wr(OFS_MODE, 16'h127F);
      wr(8'h40, 16'hFFFF);
      rd(8'h40, v);
      chk("unmapped", v, 16'h0000);
      rd(OFS_MODE, v);
      chk("mode", v, 16'h127F);
      chk("base", vector_base, 16'h1200);
      chk("maps", {13'h0, rom_in_prog, ram_in_prog, data_rom_map},
          16'h0003);
      chk("pins", {14'h0, sat_store, clock_output_pin},
          16'h0003);
      for (int i = 0; i < 4; i++) begin
         overflow_mode_bit <= i[0];
         fractional_mode_bit <= i[1];
         repeat (3) @(posedge ref_clk);
         #1;
         chk("sat", {15'h0, sat_product}, 16'(i == 3));
      end
      rd(OFS_MODE, v);
      wr(OFS_MODE, 16'h127D);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("sat", {15'h0, sat_product}, 16'h0000);
      soft_reset <= 1'b1;
      @(posedge ref_clk);
      soft_reset <= 1'b0;
      rd(OFS_MODE, v);
      chk("soft", v, 16'h1240);
      wr(OFS_MODE, 16'h1250);
      prog_addr <= 23'h2A5A5A;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("trace", ext_addr_pins[15:0], 16'h5A5A);
      wr(OFS_MODE, 16'h1240);
      acc(SPACE_DATA, 23'h001234, n7);
      prog_addr <= 23'h000F0F;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("hold", ext_addr_pins[15:0], 16'h1234);
      do_reset(1'b0);
      rd(OFS_MODE, v);
      chk("mode", v, 16'hFF80);
      chk("rom", {15'h0, rom_in_prog}, 16'h0001);
      print_verdict();
   end
endmodule
